// File: hw/byte_fifo.v
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
   parameter WIDTH = 25,
   parameter DEPTH = 8,
   parameter PTRW  = 3
) (
   input  wire             clk,      // System clock
   input  wire             reset_n,  // Async reset, active low
   input  wire [WIDTH-1:0] inData,   // Word in
   input  wire             inValid,  // Word offered
   output wire             inReady,  // Room left
   output wire [WIDTH-1:0] outData,  // Word out
   output wire             outValid, // Word available
   input  wire             outReady  // Word taken
);
   reg [WIDTH-1:0] store [0:DEPTH-1];
   reg [PTRW-1:0]  wrPtr;
   reg [PTRW-1:0]  rdPtr;
   reg [PTRW:0]    count;
   wire            doPush;
   wire            doPop;
   integer         i;

   // Flags derive from the occupancy count
   assign inReady  = (count != DEPTH[PTRW:0]);
   assign outValid = (count != {(PTRW+1){1'b0}});
   assign outData  = store[rdPtr];
   assign doPush   = inValid & inReady;
   assign doPop    = outValid & outReady;

   // Pointer and storage update
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr <= {PTRW{1'b0}};
         rdPtr <= {PTRW{1'b0}};
         count <= {(PTRW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            store[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (doPush) begin
            store[wrPtr] <= inData;
            wrPtr        <= wrPtr + 1'b1;
         end
         if (doPop) begin
            rdPtr <= rdPtr + 1'b1;
         end
         if (doPush && !doPop) begin
            count <= count + 1'b1;
         end else if (doPop && !doPush) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: hw/quad_spi_nvsram_store_ctrl.v
// Serial nonvolatile SRAM slave with store and busy-line control
// ----------------------------------------------------------------
// Summary of operation
// - Busy line low during store or recall
// - After a save, drive busy high briefly, then release; after recall, release at once
// - External low on busy line requests save
// - Write-protect pin locks writes, single/dual
// - Quad mode: write-protect becomes lane 2
// - Single: input lane 0, output lane 1
// - Sample rising edge, change falling edge
// - 128 Kbyte array, three address bytes
// - Zero latency to 40 MHz, fast above
// - Modes 0,0 and 1,1, either idle
// - Write burst increments and wraps to zero
// - Read burst increments and wraps to zero
// - Normal read: opcode, address, no dummy
// - Fast read adds one dummy byte
// - Save erases, programs; accesses refused meanwhile
// - Save shows busy line and progress flag
// - Skip pin and power saves without writes
// - Command save always runs; here a save command given while a save or recall is under way is dropped
// - Power fail blocks access, starts autosave
// - No autosave without write since recall
// - Block-protected ranges and lockout block writes
// - Decode save, recall, autosave off, on
// - Selected while select low, else standby
// - Most significant bit first
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "nv_store_defines.vh"
module quad_spi_nvsram_store_ctrl (
   input  wire       clk,             // System clock, 100 MHz
   input  wire       reset_n,         // Async reset, active low
   input  wire       serialClock,     // Link clock pin
   input  wire       chipSelect_n,    // Select, active low
   input  wire [3:0] laneIn,          // Data lanes 0..3 input
   output reg  [3:0] laneOut,         // Data lanes output
   output reg  [3:0] laneOe,          // Lane drive enables
   input  wire       writeProtect_n,  // Write protect, active low
   input  wire       busyLineIn,      // Store-busy line level
   output reg        busyLineOut,     // Store-busy line drive level
   output reg        busyLineOe,      // Store-busy line drive enable
   input  wire       powerFail,       // Power-fail indication
   input  wire [1:0] laneMode,        // Single, dual or quad
   input  wire [1:0] blockProtect,    // Protected range select
   output reg        saveInProgress,  // Progress flag
   output reg        autosaveEnabled, // Autosave state
   output reg        writeLocked,     // Software lockout state
   output reg        nvWriteStrobe,   // Pulse per nonvolatile program
   output reg        recallStrobe     // Pulse when recall finishes
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   reg [1:0] sckSync;
   reg [1:0] csSync;
   reg [3:0] laneSync0;
   reg [3:0] laneSync1;
   reg [1:0] wpSync;
   reg [1:0] busySync;
   reg [1:0] pfSync;
   reg       sckLast;

   // Second stage only feeds the logic
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sckSync   <= 2'h0;
         csSync    <= 2'h3;
         laneSync0 <= 4'h0;
         laneSync1 <= 4'h0;
         wpSync    <= 2'h3;
         busySync  <= 2'h3;
         pfSync    <= 2'h0;
         sckLast   <= 1'b0;
      end else begin
         sckSync   <= {sckSync[0], serialClock};
         csSync    <= {csSync[0], chipSelect_n};
         laneSync0 <= laneIn;
         laneSync1 <= laneSync0;
         wpSync    <= {wpSync[0], writeProtect_n};
         busySync  <= {busySync[0], busyLineIn};
         pfSync    <= {pfSync[0], powerFail};
         sckLast   <= sckSync[1];
      end
   end

   wire selected = ~csSync[1];
   wire sckRise  = selected & sckSync[1] & ~sckLast;
   wire sckFall  = selected & ~sckSync[1] & sckLast;

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function [2:0] lanesOf;
      input [7:0] op;
      input [1:0] md;
      begin
         if (md == `LANE_QUAD || op == `OP_QUAD_READ ||
             op == `OP_QUAD_IO_READ || op == `OP_QUAD_WRITE ||
             op == `OP_QUAD_IO_WRITE)
            lanesOf = 3'h4;
         else if (md == `LANE_DUAL || op == `OP_DUAL_READ ||
                  op == `OP_DUAL_IO_READ || op == `OP_DUAL_WRITE ||
                  op == `OP_DUAL_IO_WRITE)
            lanesOf = 3'h2;
         else
            lanesOf = 3'h1;
      end
   endfunction

   function isProtected;
      input [1:0]            bp;
      input [`ADDR_BITS-1:0] a;
      begin
         case (bp)
            2'h1:    isProtected = (a[16:15] == 2'h3);
            2'h2:    isProtected = a[16];
            2'h3:    isProtected = 1'b1;
            default: isProtected = 1'b0;
         endcase
      end
   endfunction

   // ---------------------------------------------------------------
   // Serial transaction engine
   // ---------------------------------------------------------------
   localparam PH_OP   = 3'h0;
   localparam PH_ADDR = 3'h1;
   localparam PH_DUMY = 3'h2;
   localparam PH_WDAT = 3'h3;
   localparam PH_RDAT = 3'h4;
   localparam PH_IGN  = 3'h5;

   localparam NV_IDLE  = 3'h0;
   localparam NV_ERASE = 3'h1;
   localparam NV_PROG  = 3'h2;
   localparam NV_HIGH  = 3'h3;
   localparam NV_RCL   = 3'h4;

   reg [2:0]            phase;
   reg [7:0]            opcode;
   reg [7:0]            shiftIn;
   reg [4:0]            bitCnt;
   reg [2:0]            lanes;
   reg [`ADDR_BITS-1:0] addr;
   reg [7:0]            shiftOut;
   reg                  dataReady;
   reg [7:0]            sram [0:`MEM_BYTES-1];
   reg [7:0]            nvCell [0:`MEM_BYTES-1];
   reg                  dirty;
   reg                  writtenSinceRecall;
   reg                  saveReq;
   reg                  recallReq;
   reg                  writeEnable;
   reg [2:0]            nvState;
   reg [16:0]           nvCnt;
   reg                  saveDriveHigh;

   wire accessBlocked = (nvState != NV_IDLE) | pfSync[1];
   wire hwLockActive  = (laneMode != `LANE_QUAD) & ~wpSync[1];
   wire [2:0] opLanes = lanesOf(shiftIn, laneMode);

   // FIFO carries write bytes with their address to the array port
   wire [24:0] fifoOut;
   wire        fifoValid;
   wire        fifoReady;
   wire        wrOk = ~accessBlocked & ~hwLockActive & ~writeLocked &
                      writeEnable & ~isProtected(blockProtect, addr);
   wire        byteDone = sckRise & (bitCnt + {2'h0, lanes} >= 5'h8);
   wire        pushWr = (phase == PH_WDAT) & byteDone & wrOk;
   wire [7:0]  nextByte = (lanes == 3'h4) ? {shiftIn[3:0], laneSync1} :
                          (lanes == 3'h2) ? {shiftIn[5:0], laneSync1[1:0]} :
                                            {shiftIn[6:0], laneSync1[0]};

   byte_fifo #(
      .WIDTH (25),
      .DEPTH (`FIFO_DEPTH),
      .PTRW  (`FIFO_PTR_BITS)
   ) u_fifo (
      .clk      (clk),
      .reset_n  (reset_n),
      .inData   ({nextByte, addr}),
      .inValid  (pushWr),
      .inReady  (fifoReady),
      .outData  (fifoOut),
      .outValid (fifoValid),
      .outReady (nvState == NV_IDLE)
   );

   // Address byte count and transfer width decode
   reg  [1:0] addrBytes;
   wire       isWriteOp = (opcode == `OP_WRITE) ||
                          (opcode == `OP_DUAL_WRITE) ||
                          (opcode == `OP_QUAD_WRITE) ||
                          (opcode == `OP_DUAL_IO_WRITE) ||
                          (opcode == `OP_QUAD_IO_WRITE);
   wire [2:0] opLanesSel = lanesOf(opcode, laneMode);

   // Shift-in and phase sequencing, one bit per lane per rising edge
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase       <= PH_OP;
         opcode      <= 8'h00;
         shiftIn     <= 8'h00;
         bitCnt      <= 5'h00;
         lanes       <= 3'h1;
         addr        <= {`ADDR_BITS{1'b0}};
         saveReq     <= 1'b0;
         recallReq   <= 1'b0;
         writeEnable <= 1'b0;
         autosaveEnabled <= 1'b1;
         writeLocked <= 1'b0;
      end else begin
         saveReq   <= 1'b0;
         recallReq <= 1'b0;
         if (!selected) begin
            phase  <= PH_OP;
            bitCnt <= 5'h00;
            lanes  <= (laneMode == `LANE_SINGLE) ? 3'h1 :
                      (laneMode == `LANE_DUAL) ? 3'h2 : 3'h4;
         end else if (sckRise) begin
            shiftIn <= nextByte;
            bitCnt  <= bitCnt + {2'h0, lanes};
            if (byteDone) begin
               bitCnt <= 5'h00;
               case (phase)
                  PH_OP: begin
                     opcode <= nextByte;
                     phase  <= PH_IGN;
                     case (nextByte)
                        `OP_STORE:  saveReq <= 1'b1;
                        `OP_RECALL: recallReq <= 1'b1;
                        `OP_AS_DISABLE: autosaveEnabled <= 1'b0;
                        `OP_AS_ENABLE:  autosaveEnabled <= 1'b1;
                        `OP_WRITE_LOCKOUT: writeLocked <= 1'b1;
                        `OP_WRITE_ENABLE: begin
                           writeLocked <= 1'b0;
                           writeEnable <= 1'b1;
                        end
                        `OP_READ, `OP_FAST_READ, `OP_DUAL_READ,
                        `OP_QUAD_READ, `OP_DUAL_IO_READ,
                        `OP_QUAD_IO_READ, `OP_WRITE, `OP_DUAL_WRITE,
                        `OP_QUAD_WRITE, `OP_DUAL_IO_WRITE,
                        `OP_QUAD_IO_WRITE: begin
                           phase <= PH_ADDR;
                           if (nextByte == `OP_DUAL_IO_READ ||
                               nextByte == `OP_QUAD_IO_READ ||
                               nextByte == `OP_DUAL_IO_WRITE ||
                               nextByte == `OP_QUAD_IO_WRITE)
                              lanes <= lanesOf(nextByte, laneMode);
                        end
                        default: phase <= PH_IGN;
                     endcase
                  end
                  PH_ADDR: begin
                     addr <= {addr[8:0], nextByte};
                     opcode[7] <= 1'b0;
                     if (bitCnt == 5'h00 && opcode[7:5] == 3'h0 &&
                         shiftIn == 8'h00) begin
                        phase <= PH_ADDR;
                     end
                     // Address byte count kept in its own register, addrBytes
                     if (addrBytes == 2'h2) begin
                        lanes <= opLanesSel;
                        if (isWriteOp) phase <= PH_WDAT;
                        else if (opcode == `OP_READ)
                           phase <= PH_RDAT;
                        else phase <= PH_DUMY;
                     end
                  end
                  PH_DUMY: phase <= PH_RDAT;
                  PH_WDAT: addr <= (addr == `ADDR_LAST) ?
                           {`ADDR_BITS{1'b0}} : addr + 1'b1;
                  PH_RDAT: addr <= (addr == `ADDR_LAST) ?
                           {`ADDR_BITS{1'b0}} : addr + 1'b1;
                  default: phase <= PH_IGN;
               endcase
            end
         end
      end
   end

   // Address byte counter
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addrBytes <= 2'h0;
      end else if (!selected) begin
         addrBytes <= 2'h0;
      end else if (sckRise && byteDone && phase == PH_ADDR) begin
         addrBytes <= addrBytes + 1'b1;
      end
   end

   // Read data: load on byte boundary, shift out on falling edge
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         shiftOut  <= 8'h00;
         dataReady <= 1'b0;
         laneOut   <= 4'h0;
         laneOe    <= 4'h0;
      end else if (!selected || phase != PH_RDAT || accessBlocked) begin
         laneOe    <= 4'h0;
         dataReady <= 1'b0;
      end else if (sckFall) begin
         if (!dataReady || bitCnt == 5'h00) begin
            shiftOut  <= sram[addr];
            dataReady <= 1'b1;
         end
         laneOe <= (lanes == 3'h4) ? 4'hF :
                   (lanes == 3'h2) ? 4'h3 : 4'h2;
         if (lanes == 3'h4)
            laneOut <= (bitCnt == 5'h00) ? sram[addr][7:4] : shiftOut[3:0];
         else if (lanes == 3'h2)
            laneOut <= {2'h0, sram[addr][7 - bitCnt[2:0] -: 2]};
         else
            laneOut <= {2'h0, sram[addr][3'h7 - bitCnt[2:0]], 1'b0};
      end
   end

   // ---------------------------------------------------------------
   // Save and recall sequencer
   // ---------------------------------------------------------------
   reg busyLast;
   wire hwSaveReq = ~busySync[1] & busyLast & ~busyLineOe;
   integer k;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nvState            <= NV_IDLE;
         nvCnt              <= 17'h00000;
         dirty              <= 1'b0;
         writtenSinceRecall <= 1'b0;
         busyLast           <= 1'b1;
         busyLineOut        <= 1'b1;
         busyLineOe         <= 1'b0;
         saveInProgress     <= 1'b0;
         nvWriteStrobe      <= 1'b0;
         recallStrobe       <= 1'b0;
      end else begin
         busyLast      <= busySync[1];
         nvWriteStrobe <= 1'b0;
         recallStrobe  <= 1'b0;
         if (fifoValid && nvState == NV_IDLE) begin
            sram[fifoOut[16:0]] <= fifoOut[24:17];
            dirty              <= 1'b1;
            writtenSinceRecall <= 1'b1;
         end
         case (nvState)
            NV_IDLE: begin
               busyLineOe <= 1'b0;
               if (saveReq ||
                   (hwSaveReq && dirty) ||
                   (pfSync[1] && autosaveEnabled && dirty &&
                    writtenSinceRecall)) begin
                  nvState <= NV_ERASE;
                  nvCnt   <= 17'h00000;
               end else if (recallReq) begin
                  nvState <= NV_RCL;
                  nvCnt   <= 17'h00000;
               end
            end
            NV_ERASE: begin
               if (nvCnt == `STORE_CYCLES - 1) begin
                  nvState <= NV_PROG;
                  nvCnt   <= 17'h00000;
               end else begin
                  nvCnt <= nvCnt + 1'b1;
               end
            end
            NV_PROG: begin
               // Sixteen bytes a cycle keeps a save short to poll
               for (k = 0; k < 16; k = k + 1) begin
                  nvCell[{nvCnt[12:0], k[3:0]}] <=
                     sram[{nvCnt[12:0], k[3:0]}];
               end
               nvWriteStrobe <= 1'b1;
               if (nvCnt == 17'h01FFF) begin
                  nvState <= NV_HIGH;
                  dirty   <= 1'b0;
                  nvCnt   <= 17'h00000;
               end else begin
                  nvCnt <= nvCnt + 1'b1;
               end
            end
            NV_HIGH: begin
               if (nvCnt == `BUSY_HIGH_CYCLES) nvState <= NV_IDLE;
               nvCnt <= nvCnt + 1'b1;
            end
            NV_RCL: begin
               for (k = 0; k < 16; k = k + 1) begin
                  sram[{nvCnt[12:0], k[3:0]}] <=
                     nvCell[{nvCnt[12:0], k[3:0]}];
               end
               if (nvCnt == 17'h01FFF) begin
                  nvState            <= NV_IDLE;
                  recallStrobe       <= 1'b1;
                  dirty              <= 1'b0;
                  writtenSinceRecall <= 1'b0;
                  nvCnt              <= 17'h00000;
               end else begin
                  nvCnt <= nvCnt + 1'b1;
               end
            end
            default: nvState <= NV_IDLE;
         endcase
         saveInProgress <= (nvState == NV_ERASE) ||
                           (nvState == NV_PROG);
         busyLineOe  <= (nvState != NV_IDLE);
         // Idle level stays high so a released line never reads busy
         busyLineOut <= (nvState == NV_HIGH) ||
                        (nvState == NV_IDLE);
      end
   end
endmodule
`default_nettype wire

// File: include/nv_store_defines.vh
// Constants for the serial nonvolatile SRAM slave
`ifndef NV_STORE_DEFINES_VH
`define NV_STORE_DEFINES_VH
`define ADDR_BITS        17
`define MEM_BYTES        131072
`define ADDR_LAST        17'h1FFFF
`define LANE_SINGLE      2'h0
`define LANE_DUAL        2'h1
`define LANE_QUAD        2'h2
`define OP_READ          8'h01
`define OP_FAST_READ     8'h02
`define OP_DUAL_READ     8'h03
`define OP_QUAD_READ     8'h04
`define OP_DUAL_IO_READ  8'h05
`define OP_QUAD_IO_READ  8'h06
`define OP_WRITE         8'h07
`define OP_DUAL_WRITE    8'h08
`define OP_QUAD_WRITE    8'h09
`define OP_DUAL_IO_WRITE 8'h0A
`define OP_QUAD_IO_WRITE 8'h0B
`define OP_STORE         8'h0C
`define OP_RECALL        8'h0D
`define OP_AS_DISABLE    8'h0E
`define OP_AS_ENABLE     8'h0F
`define OP_WRITE_LOCKOUT 8'h10
`define OP_WRITE_ENABLE  8'h11
`define STORE_TIME_NS    1000
`define STORE_CYCLES     ((`STORE_TIME_NS + 9) / 10)
`define RECALL_TIME_NS   500
`define RECALL_CYCLES    ((`RECALL_TIME_NS + 9) / 10)
`define BUSY_HIGH_NS     50
`define BUSY_HIGH_CYCLES (`BUSY_HIGH_NS / 10)
`define FIFO_DEPTH       8
`define FIFO_PTR_BITS    3
`endif

// File: tb/nv_store_properties.sv
// Port checks for the nonvolatile SRAM slave
`timescale 1ns/1ps
`default_nettype none
`include "nv_store_defines.vh"
module nv_store_properties (
   input wire logic       clk,             // Clock
   input wire logic       reset_n,         // Reset, low
   input wire logic       serialClock,     // Link clock
   input wire logic       chipSelect_n,    // Select, low
   input wire logic [3:0] laneIn,          // Lane levels
   input wire logic [3:0] laneOut,         // Lane drive
   input wire logic [3:0] laneOe,          // Lane enables
   input wire logic       writeProtect_n,  // Write protect
   input wire logic       busyLineIn,      // Busy level
   input wire logic       busyLineOut,     // Busy drive
   input wire logic       busyLineOe,      // Busy enable
   input wire logic       powerFail,       // Power fail
   input wire logic [1:0] laneMode,        // Lane mode
   input wire logic [1:0] blockProtect,    // Range select
   input wire logic       saveInProgress,  // Progress flag
   input wire logic       autosaveEnabled, // Autosave
   input wire logic       writeLocked,     // Lockout
   input wire logic       nvWriteStrobe,   // Program pulse
   input wire logic       recallStrobe     // Recall pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ----------
   // Busy line
   // ----------
   a_busy_low_save: assert property (
      saveInProgress |-> busyLineOe && !busyLineOut)
      else $error("busy line not driven low in save");
   a_busy_high_drive: assert property (
      $fell(saveInProgress) |-> ##[0:2] (busyLineOe && busyLineOut))
      else $error("busy line not driven high after save");
   // Release bounded so a stuck driver is seen
   a_busy_release: assert property (
      $fell(saveInProgress) |-> ##[1:20] !busyLineOe)
      else $error("busy line never released");
   a_save_min_len: assert property (
      $rose(saveInProgress) |=> saveInProgress [*8])
      else $error("save cut short");
   a_strobe_in_save: assert property (
      nvWriteStrobe |-> saveInProgress)
      else $error("program pulse outside save");
   // ----------
   // Lanes
   // ----------
   a_idle_no_drive: assert property (
      chipSelect_n [*5] |-> laneOe == 4'h0)
      else $error("lanes driven while deselected");
   a_single_lanes: assert property (
      laneMode == `LANE_SINGLE |-> !laneOe[0] && laneOe[3:2] == 2'h0)
      else $error("wrong lane driven in single mode");
   // Raw clock is still low three cycles after its fall
   a_out_low_clk: assert property (
      $changed(laneOut[1]) && laneOe[1] |-> !serialClock)
      else $error("output changed with link clock high");
   c_save: cover property ($rose(saveInProgress));
   c_autosave_off: cover property ($fell(autosaveEnabled));
   c_lock: cover property ($rose(writeLocked));
endmodule
bind quad_spi_nvsram_store_ctrl nv_store_properties chk (
   .clk, .reset_n, .serialClock, .chipSelect_n, .laneIn, .laneOut,
   .laneOe, .writeProtect_n, .busyLineIn, .busyLineOut, .busyLineOe,
   .powerFail, .laneMode, .blockProtect, .saveInProgress,
   .autosaveEnabled, .writeLocked, .nvWriteStrobe, .recallStrobe);
`default_nettype wire

// File: tb/spi_master_model.sv
// Serial bus master driving clock, select and lane 0
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   output logic      sck,  // Link clock, idles low
   output logic      csN,  // Select, active low
   output logic      mosi, // Lane 0 drive
   input  wire logic miso  // Lane 1 level
);
   logic [7:0] rxByte; // Last byte captured
   event       got;    // Captured byte ready
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      mosi = 1'b0;
   end
   // 8 MHz, well under the zero-latency limit; mode 0,0
   task automatic xfer(input logic [7:0] b, input bit cap);
      for (int i = 7; i >= 0; i--) begin
         mosi = b[i];
         #62.5 sck = 1'b1;
         rxByte = {rxByte[6:0], miso};
         #62.5 sck = 1'b0;
      end
      if (cap) ->got;
   endtask
   // Opcode first after select falls
   task automatic start(input logic [7:0] op);
      csN = 1'b0;
      #125 xfer(op, 1'b0);
   endtask
   // Deselect before any new opcode; lane 0 stops holding its value
   task automatic stop();
      #125 csN = 1'b1;
      mosi = ~mosi;
      #500;
   endtask
   // Opcode, three address bytes, dummy if fast, two data bytes
   task automatic mem(input logic [7:0] op, input logic [23:0] a,
                      input bit fast, input bit rd, input logic [7:0] w[2]);
      start(op);
      for (int k = 2; k >= 0; k--) xfer(a[8*k+:8], 1'b0);
      if (fast) xfer(8'h00, 1'b0);
      foreach (w[k]) xfer(rd ? 8'h00 : w[k], rd);
      stop();
   endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the nonvolatile SRAM slave
`timescale 1ns/1ps
`default_nettype none
`include "nv_store_defines.vh"
module tb;
   localparam logic [23:0] LAST = {7'h00, `ADDR_LAST};
   logic       clk = 1'b0, reset_n = 1'b0, tgl = 1'b0;
   logic       writeProtect_n = 1'b1, powerFail = 1'b0, busyPull = 1'b0;
   logic [1:0] laneMode = `LANE_SINGLE, blockProtect = 2'h0;
   wire  [3:0] laneIn, laneOut, laneOe;
   wire        serialClock, chipSelect_n, mosi, busyLine;
   wire        busyLineOut, busyLineOe, saveInProgress, autosaveEnabled;
   wire        writeLocked, nvWriteStrobe, recallStrobe;
   int         error_cnt = 0, check_count = 0;
   logic [7:0] expQ[$], d[2];
   // ----------
   // Clock and wiring
   // ----------
   always #5 clk = ~clk;
   always @(posedge clk) tgl <= ~tgl;
   // Released lanes toggle so stale data cannot pass; busy line pulls up
   assign laneIn = {(laneOe[3:1] & laneOut[3:1]) |
                    (~laneOe[3:1] & {3{tgl}}), mosi};
   assign busyLine = busyLineOe ? busyLineOut : ~busyPull;
   quad_spi_nvsram_store_ctrl dut (.clk, .reset_n, .serialClock,
      .chipSelect_n, .laneIn, .laneOut, .laneOe, .writeProtect_n,
      .busyLineIn(busyLine), .busyLineOut, .busyLineOe, .powerFail,
      .laneMode, .blockProtect, .saveInProgress, .autosaveEnabled,
      .writeLocked, .nvWriteStrobe, .recallStrobe);
   spi_master_model m (.sck(serialClock), .csN(chipSelect_n), .mosi,
      .miso(laneIn[1]));
   // ----------
   // Tasks
   // ----------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] op);
      m.start(op);
      m.stop();
   endtask
   // Sampled on the falling edge, clear of the launching edge
   task automatic waitSave(input logic v);
      int n;
      n = 0;
      while (saveInProgress !== v && n < 300000) begin
         @(negedge clk);
         n++;
      end
      repeat (20) @(negedge clk);
   endtask
   task automatic pullBusy();
      @(posedge clk) busyPull <= 1'b1;
      repeat (10) @(posedge clk);
      busyPull <= 1'b0;
      repeat (50) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] w[2]);
      cmd(`OP_WRITE_ENABLE);
      m.mem(`OP_WRITE, LAST, 1'b0, 1'b0, w);
   endtask
   task automatic rd(input logic [7:0] op, input bit fast);
      expQ.push_back(d[0]);
      expQ.push_back(d[1]);
      m.mem(op, LAST, fast, 1'b1, d);
   endtask
   // Each read byte is matched with the oldest note
   always @(m.got) check(m.rxByte, expQ.pop_front());
   initial begin
      #900_000;
      error_cnt++;
      conclude();
   end
   // ----------
   // Tests
   // ----------
   initial begin
      void'($urandom(95));
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      check(busyLineOut, 1'b1);
      check(autosaveEnabled, 1'b1);
      cmd(`OP_AS_DISABLE);
      check(autosaveEnabled, 1'b0);
      cmd(`OP_AS_ENABLE);
      check(autosaveEnabled, 1'b1);
      $display("Test reset and autosave done");
      cmd(`OP_STORE);
      waitSave(1'b1);
      check(busyLine, 1'b0);
      waitSave(1'b0);
      check(busyLine, 1'b1);
      pullBusy();
      check(saveInProgress, 1'b0);
      $display("Test store command done");
      d[0] = 8'($urandom);
      d[1] = 8'($urandom);
      wr(d);
      rd(`OP_READ, 1'b0);
      rd(`OP_FAST_READ, 1'b1);
      $display("Test burst wrap done");
      @(posedge clk) writeProtect_n <= 1'b0;
      wr('{~d[0], ~d[1]});
      rd(`OP_READ, 1'b0);
      @(posedge clk) writeProtect_n <= 1'b1;
      $display("Test write protect done");
      pullBusy();
      check(saveInProgress, 1'b1);
      waitSave(1'b0);
      $display("Test busy line save done");
      wr(d);
      @(posedge clk) powerFail <= 1'b1;
      waitSave(1'b1);
      check(saveInProgress, 1'b1);
      waitSave(1'b0);
      @(posedge clk) powerFail <= 1'b0;
      $display("Test power fail done");
      @(posedge clk) reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      cmd(`OP_WRITE_ENABLE);
      cmd(`OP_WRITE_LOCKOUT);
      check(writeLocked, 1'b1);
      $display("Test lockout done");
      conclude();
   end
endmodule
`default_nettype wire
